/* File: testbench/host_model.sv */
`timescale 1ns/1ps
// ======================================
// host side of the command port
module host_model (
  input  wire logic        clock_i,
  input  wire logic [15:0] rd_data_i,
  output logic      [7:0]  cmd_code_o,
  output logic      [15:0] wr_data_o,
  output logic             wr_en_o
);
  initial begin
    cmd_code_o = 8'h00;
    wr_data_o = 16'h0000;
    wr_en_o = 1'b0;
  end
  task automatic write(input logic [7:0] c, input logic [15:0] d);
    @(negedge clock_i);
    cmd_code_o = c;
    wr_data_o = d;
    wr_en_o = 1'b1;
    @(negedge clock_i);
    wr_en_o = 1'b0;
    // stale word inverted so it never passes for fresh data
    wr_data_o = ~d;
  endtask
  task automatic read(input logic [7:0] c, output logic [15:0] d);
    @(negedge clock_i);
    cmd_code_o = c;
    @(negedge clock_i);
    d = rd_data_i;
  endtask
endmodule

/* File: testbench/oc_fault_retry_props.sv */
`timescale 1ns/1ps
// ======================================
// port checks of the over-current logic
module oc_fault_retry_props (
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  cmd_code_i,
  input wire logic [15:0] wr_data_i,
  input wire logic        wr_en_i,
  input wire logic [15:0] rd_data_o,
  input wire logic        oc_detect_i,
  input wire logic        on_request_i,
  input wire logic        bias_ok_i,
  input wire logic        other_fault_i,
  input wire logic        output_enable_o,
  input wire logic        oc_fault_o,
  input wire logic        alert_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  wire clr_w = wr_en_i && cmd_code_i == 8'he2;
  AST_FLT_HOLD: assert property (
    oc_fault_o && !clr_w |=> oc_fault_o)
    else $error("fault lost");
  AST_ALR_HOLD: assert property (alert_o && !clr_w |=> alert_o)
    else $error("alert lost");
  // pin low long enough that no set is still in the sync pipe
  AST_CLEAR: assert property (
    !oc_detect_i [*4] ##0 clr_w |=> !oc_fault_o)
    else $error("clear ignored");
  AST_OTHER_OFF: assert property (
    other_fault_i [*4] |-> !output_enable_o)
    else $error("on in fault");
  AST_BIAS_OFF: assert property (
    !bias_ok_i [*6] |-> !output_enable_o)
    else $error("on sans bias");
  AST_ON_OFF: assert property (
    !on_request_i [*6] |-> !output_enable_o)
    else $error("on when off");
  AST_LV_READ: assert property ((wr_en_i && cmd_code_i == 8'h48)
    ##1 (!wr_en_i && cmd_code_i == 8'h48) |=> rd_data_o == $past(wr_data_i, 2))
    else $error("bad threshold");
  AST_UNIT_READ: assert property ((wr_en_i && cmd_code_i == 8'hc8)
    ##1 (!wr_en_i && cmd_code_i == 8'hc8) |=> rd_data_o == $past(wr_data_i, 2))
    else $error("bad unit");
endmodule
bind oc_fault_retry oc_fault_retry_props chk_u (.clock_i, .rst_n_i,
  .cmd_code_i, .wr_data_i, .wr_en_i, .rd_data_o, .oc_detect_i, .on_request_i,
  .bias_ok_i, .other_fault_i, .output_enable_o, .oc_fault_o, .alert_o);

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
`include "oc_retry_regs.svh"
// ======================================
// bench top
module tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        oc = 1'b0;
  logic        on_req = 1'b0;
  logic        bias = 1'b0;
  logic        other = 1'b0;
  logic [15:0] vout = 16'h0100;
  logic [15:0] rdata, wdata, v;
  logic [7:0]  cmd;
  logic        wen, oe, lim, flt, alrt;
  int          error_cnt = 0;
  int          check_count = 0;
  int          n, t0, t1, sp0;
  always #12.5 clk = ~clk;
  oc_fault_retry #(.UNIT_W(16)) dut_u (.clock_i(clk), .rst_n_i(rst_n),
    .cmd_code_i(cmd), .wr_data_i(wdata), .wr_en_i(wen), .rd_data_o(rdata),
    .oc_detect_i(oc), .on_request_i(on_req), .bias_ok_i(bias),
    .other_fault_i(other), .vout_i(vout), .output_enable_o(oe),
    .current_limit_o(lim), .oc_fault_o(flt), .alert_o(alrt));
  host_model host_u (.clock_i(clk), .rd_data_i(rdata), .cmd_code_o(cmd),
    .wr_data_o(wdata), .wr_en_o(wen));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // off, program, clear, on again: every episode starts from a full count
  task automatic arm(input logic [7:0] act);
    oc = 1'b0;
    on_req = 1'b0;
    repeat (6) @(negedge clk);
    host_u.write(`CMD_FAULT_ACTION, {8'h00, act});
    host_u.write(`CMD_CLEAR_FAULTS, 16'h0000);
    on_req = 1'b1;
    for (int k = 0; k < 40 && oe !== 1'b1; k++) @(negedge clk);
    check(16'(oe), 16'h0001);
    oc = 1'b1;
  endtask
  task automatic count_rises(input int win);
    logic p;
    p = oe;
    n = 0;
    for (int k = 0; k < win; k++) begin
      @(negedge clk);
      if (oe === 1'b1 && p !== 1'b1) begin
        n++;
        t0 = (n == 1) ? k : t0;
        t1 = (n == 2) ? k : t1;
      end
      p = oe;
    end
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    host_u.read(`CMD_LV_THRESHOLD, v);
    check(v, `LV_THRESHOLD_RST);
    host_u.read(`CMD_TIME_UNIT, v);
    check(v, `TIME_UNIT_RST);
    host_u.read(`CMD_FAULT_ACTION, v);
    check(v, {8'h00, `FAULT_ACTION_RST});
    host_u.read(8'h55, v);
    check(v, 16'h0000);
    bias = 1'b1;
    host_u.write(`CMD_LV_THRESHOLD, 16'h8200);
    host_u.read(`CMD_LV_THRESHOLD, v);
    check(v, 16'h8200);
    host_u.write(`CMD_TIME_UNIT, 16'h0001);
    for (int r = 0; r < 7; r++) begin
      arm({2'b11, 3'(r), 3'b000});
      count_rises(200);
      check(16'(n), 16'(r));
      check(16'(oe), 16'h0000);
    end
    // latched with the output still requested: a clear brings it back, as would a loss of bias or a pulse on other_fault_i
    repeat (20) @(negedge clk);
    check(16'(oe), 16'h0000);
    oc = 1'b0;
    repeat (4) @(negedge clk);
    host_u.read(`CMD_FAULT_STATUS, v);
    check(v, 16'h0003);
    host_u.write(`CMD_CLEAR_FAULTS, 16'h0000);
    repeat (4) @(negedge clk);
    check(16'(oe), 16'h0001);
    check({14'h0000, flt, alrt}, 16'h0000);
    arm(8'hd0);
    count_rises(200);
    sp0 = t1 - t0;
    // spacing overhead cancels out, leaving the decoded delay less the one-cycle delay of the baseline
    for (int k = 1; k < 3; k++) begin
      host_u.write(`CMD_TIME_UNIT, 16'(k));
      arm(8'hd7);
      count_rises(700);
      check(16'(t1 - t0 - sp0), 16'(128 * k - 1));
    end
    host_u.write(`CMD_TIME_UNIT, 16'h0001);
    arm(8'hf8);
    count_rises(200);
    check(16'(n > 7), 16'h0001);
    other = 1'b1;
    repeat (6) @(negedge clk);
    check(16'(oe), 16'h0000);
    count_rises(40);
    check(16'(n), 16'h0000);
    other = 1'b0;
    // one short fault, a clean restart, then a second fault
    arm(8'hc8);
    repeat (3) @(negedge clk);
    oc = 1'b0;
    repeat (10) @(negedge clk);
    host_u.read(`CMD_FAULT_STATUS, v);
    check(v, 16'h0011);
    oc = 1'b1;
    count_rises(100);
    check(16'(n), 16'h0001);
    check(16'(oe), 16'h0000);
    for (int m = 0; m < 4; m++) begin
      arm({2'(m), 6'b000100});
      repeat (6) @(negedge clk);
      check(16'(oe), 16'(m == 0 || m == 2));
      repeat (40) @(negedge clk);
      check(16'(oe), 16'(m == 0));
      check(16'(lim), 16'(m == 0));
      check({14'h0000, flt, alrt}, 16'h0003);
    end
    // conditioned limiting: holds while vout stays above the threshold
    vout = 16'h9000;
    arm(8'h44);
    repeat (40) @(negedge clk);
    check(16'(oe), 16'h0001);
    check(16'(lim), 16'h0001);
    vout = 16'h0100;
    repeat (6) @(negedge clk);
    check(16'(oe), 16'h0000);
    check(16'(lim), 16'h0000);
    close_out();
  end
  initial begin
    #2000000;
    error_cnt++;
    close_out();
  end
endmodule

/* File: verilog/delay_if.sv */
`timescale 1ns/1ps
interface delay_if #(
  parameter int UNIT_W = 16
);
  logic              start;
  logic [2:0]        shift;
  logic [UNIT_W-1:0] unit;
  logic              done;

  modport ctrl  (output start, output shift, output unit, input done);
  modport timer (input start, input shift, input unit, output done);
endinterface

/* File: verilog/delay_timer.sv */
`timescale 1ns/1ps
module delay_timer #(
  parameter int UNIT_W = 16
) (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  delay_if.timer    tmr
);
  localparam int CNT_W = UNIT_W + 8;

  logic [CNT_W-1:0] cnt_r;
  logic             done_r;
  wire  [CNT_W-1:0] load_val;
  wire  [CNT_W-1:0] load_min;

  // ==========================================================
  // load value
  // a zero time unit still waits one cycle so the sequence advances
  assign load_val = {{(CNT_W-UNIT_W){1'b0}}, tmr.unit} << tmr.shift;
  assign load_min = (load_val == '0) ? {{(CNT_W-1){1'b0}}, 1'b1} : load_val;

  // ==========================================================
  // down counter
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r  <= '0;
      done_r <= 1'b0;
    end else if (tmr.start) begin
      cnt_r  <= load_min;
      done_r <= 1'b0;
    end else begin
      cnt_r  <= (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
      done_r <= (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1});
    end
  end

  assign tmr.done = done_r;
endmodule

/* File: verilog/oc_fault_retry.sv */
`timescale 1ns/1ps
`include "oc_retry_regs.svh"
module oc_fault_retry
  import oc_retry_pkg::*;
#(
  parameter int UNIT_W = 16
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  cmd_code_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic        wr_en_i,
  output logic      [15:0] rd_data_o,
  input  wire logic        oc_detect_i,
  input  wire logic        on_request_i,
  input  wire logic        bias_ok_i,
  input  wire logic        other_fault_i,
  input  wire logic [15:0] vout_i,
  output logic             output_enable_o,
  output logic             current_limit_o,
  output logic             oc_fault_o,
  output logic             alert_o
);
  // the 16-bit write data and the read mux serve at most a 16-bit unit
  if (UNIT_W < 1 || UNIT_W > 16) begin : g_bad_unit_w
    $error("UNIT_W must be 1 to 16");
  end

  // ==========================================================
  // attempts allowed by a retry code
  function automatic logic [2:0] retry_allow(input logic [2:0] code);
    retry_allow = code;
  endfunction

  // ==========================================================
  // pin synchronisers
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= {bias_ok_i, on_request_i, oc_detect_i};
      sync2_r <= sync1_r;
    end
  end
  wire oc_s   = sync2_r[0];
  wire on_s   = sync2_r[1];
  wire bias_s = sync2_r[2];

  // ==========================================================
  // registers
  logic [15:0]       lv_threshold_r;
  logic [UNIT_W-1:0] time_unit_r;
  logic [7:0]        fault_action_r;
  logic              oc_fault_r;
  logic              alert_r;
  logic [2:0]        left_r;
  logic [2:0]        left_nxt;
  oc_state_e         state_r;
  oc_state_e         state_nxt;
  logic              proving_r;
  logic              proving_nxt;
  logic [15:0]       rd_data_r;
  logic              out_en_r;
  logic              limit_r;

  wire oc_mode_e mode   =
    oc_mode_e'(fault_action_r[`ACT_MODE_HI:`ACT_MODE_LO]);
  wire [2:0] retry_code = fault_action_r[`ACT_RETRY_HI:`ACT_RETRY_LO];
  wire [2:0] delay_code = fault_action_r[`ACT_DELAY_HI:`ACT_DELAY_LO];
  wire       forever_on = (retry_code == `RETRY_FOREVER);

  // ==========================================================
  // command decode
  wire wr_thr   = wr_en_i && (cmd_code_i == `CMD_LV_THRESHOLD);
  wire wr_unit  = wr_en_i && (cmd_code_i == `CMD_TIME_UNIT);
  wire wr_act   = wr_en_i && (cmd_code_i == `CMD_FAULT_ACTION);
  wire clear    = wr_en_i && (cmd_code_i == `CMD_CLEAR_FAULTS);
  // unsigned compare, both in 2^-11 volt counts
  wire vout_low = (vout_i < lv_threshold_r);
  wire may_run  = on_s && bias_s && !other_fault_i;

  // ==========================================================
  // read back
  wire [15:0] status_word = {9'h000, left_r, 1'b0,
                             limit_r, (state_r == ST_LATCHED), oc_fault_r};
  wire [15:0] rd_mux;
  assign rd_mux =
    (cmd_code_i == `CMD_LV_THRESHOLD) ? lv_threshold_r :
    (cmd_code_i == `CMD_TIME_UNIT)    ? 16'(time_unit_r) :
    (cmd_code_i == `CMD_FAULT_ACTION) ? {8'h00, fault_action_r} :
    (cmd_code_i == `CMD_FAULT_STATUS) ? status_word : 16'h0000;

  // ==========================================================
  // delay timer
  delay_if #(.UNIT_W(UNIT_W)) dly ();
  logic start_w;
  assign dly.start = start_w;
  assign dly.shift = delay_code;
  assign dly.unit  = time_unit_r;

  delay_timer #(.UNIT_W(UNIT_W)) u_timer (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .tmr     (dly.timer)
  );

  // ==========================================================
  // fault sequencer
  logic shut_w;
  always_comb begin
    state_nxt   = state_r;
    left_nxt    = left_r;
    proving_nxt = proving_r;
    start_w     = 1'b0;
    shut_w      = 1'b0;
    case (state_r)
      ST_OFF: begin
        if (may_run) begin
          state_nxt = ST_RUN;
          left_nxt  = retry_allow(retry_code);
        end
      end
      ST_RUN: begin
        if (proving_r && dly.done && !oc_s) begin
          proving_nxt = 1'b0;
          left_nxt    = retry_allow(retry_code);
        end
        if (oc_s) begin
          case (mode)
            MODE_IGNORE: shut_w = 1'b0;
            MODE_COND_LIMIT: shut_w = vout_low;
            MODE_DELAY_LIMIT: begin
              state_nxt = ST_LIMIT_DELAY;
              start_w   = 1'b1;
            end
            default: shut_w = 1'b1;
          endcase
        end
      end
      ST_LIMIT_DELAY: begin
        if (!oc_s) begin
          state_nxt = ST_RUN;
        end else if (dly.done) begin
          shut_w = 1'b1;
        end
      end
      ST_RETRY_WAIT: begin
        if (dly.done) begin
          state_nxt   = ST_RUN;
          proving_nxt = 1'b1;
          start_w     = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_LATCHED;
      end
    endcase
    if (shut_w) begin
      proving_nxt = 1'b0;
      if (forever_on) begin
        state_nxt = ST_RETRY_WAIT;
        start_w   = 1'b1;
      end else if (left_r == 3'h0) begin
        state_nxt = ST_LATCHED;
      end else begin
        state_nxt = ST_RETRY_WAIT;
        left_nxt  = left_r - 3'h1;
        start_w   = 1'b1;
      end
    end
    if (clear && state_r == ST_LATCHED) begin
      state_nxt = ST_OFF;
      left_nxt  = retry_allow(retry_code);
    end
    if (!may_run) begin
      state_nxt   = ST_OFF;
      proving_nxt = 1'b0;
    end
  end

  // a new over-current event in the clear cycle keeps the flag set
  wire oc_event = oc_s && (state_r == ST_RUN);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lv_threshold_r <= `LV_THRESHOLD_RST;
      time_unit_r    <= UNIT_W'(`TIME_UNIT_RST);
      fault_action_r <= `FAULT_ACTION_RST;
      state_r        <= ST_OFF;
      left_r         <= 3'h0;
      proving_r      <= 1'b0;
      oc_fault_r     <= 1'b0;
      alert_r        <= 1'b0;
      rd_data_r      <= 16'h0000;
      out_en_r       <= 1'b0;
      limit_r        <= 1'b0;
    end else begin
      if (wr_thr) lv_threshold_r <= wr_data_i;
      if (wr_unit) time_unit_r <= wr_data_i[UNIT_W-1:0];
      if (wr_act) fault_action_r <= wr_data_i[7:0];
      state_r    <= state_nxt;
      left_r     <= left_nxt;
      proving_r  <= proving_nxt;
      oc_fault_r <= oc_event | (oc_fault_r & ~clear);
      alert_r    <= oc_event | (alert_r & ~clear);
      rd_data_r  <= rd_mux;
      out_en_r   <= (state_nxt == ST_RUN) || (state_nxt == ST_LIMIT_DELAY);
      limit_r    <= oc_s && ((state_nxt == ST_RUN)
                             || (state_nxt == ST_LIMIT_DELAY));
    end
  end

  // ==========================================================
  // outputs
  assign rd_data_o       = rd_data_r;
  assign output_enable_o = out_en_r;
  assign current_limit_o = limit_r;
  assign oc_fault_o      = oc_fault_r;
  assign alert_o         = alert_r;
endmodule

/* File: verilog/oc_retry_pkg.sv */
package oc_retry_pkg;
  typedef enum logic [1:0] {
    MODE_IGNORE,
    MODE_COND_LIMIT,
    MODE_DELAY_LIMIT,
    MODE_DISABLE
  } oc_mode_e;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_RUN,
    ST_LIMIT_DELAY,
    ST_RETRY_WAIT,
    ST_LATCHED
  } oc_state_e;
endpackage

/* File: verilog/oc_retry_regs.svh */
`ifndef OC_RETRY_REGS_SVH
`define OC_RETRY_REGS_SVH

// ==========================================================
// command codes
`define CMD_LV_THRESHOLD  8'h48
`define CMD_TIME_UNIT     8'hc8
`define CMD_FAULT_ACTION  8'he0
`define CMD_FAULT_STATUS  8'he1
`define CMD_CLEAR_FAULTS  8'he2

// ==========================================================
// fault action fields
`define ACT_MODE_HI       7
`define ACT_MODE_LO       6
`define ACT_RETRY_HI      5
`define ACT_RETRY_LO      3
`define ACT_DELAY_HI      2
`define ACT_DELAY_LO      0

// ==========================================================
// status fields
`define STAT_OC_FAULT     0
`define STAT_LATCHED_OFF  1
`define STAT_LIMITING     2
`define STAT_LEFT_LO      4
`define STAT_LEFT_HI      6

// ==========================================================
// reset values and the endless-retry code
`define LV_THRESHOLD_RST  16'h0000
`define TIME_UNIT_RST     16'h0028
`define FAULT_ACTION_RST  8'hc0
`define RETRY_FOREVER     3'h7

`endif
